// ==== verilog/ddr_dq_turn_pkg.sv ====
// shared types and constants for the dq turnaround controller
package ddr_dq_turn_pkg;

  // command code is {load_strobe_n, direction} as sampled on the command clock
  typedef enum logic [1:0] {
    CMD_WRITE   = 2'b00,
    CMD_READ    = 2'b01,
    CMD_IDLE_WR = 2'b10,
    CMD_IDLE_RD = 2'b11
  } cmd_t;

  // state of the data bus during one command-clock cycle
  typedef enum logic [1:0] {
    BUS_TERM  = 2'b00,
    BUS_LOW   = 2'b01,
    BUS_RDATA = 2'b10,
    BUS_UNDEF = 2'b11
  } bus_state_t;

  // field positions inside a command code
  localparam int DIR_BIT = 0;
  localparam int LSN_BIT = 1;

  // data bus geometry: two beats per command cycle
  localparam int BEAT_WIDTH = 18;
  localparam int BEATS      = 2;

  // command history depth used to place bus states and write capture
  localparam int HIST_DEPTH = 3;

  // command assumed in the history after reset: keeps the bus driven low
  localparam cmd_t CMD_RESET = CMD_IDLE_RD;

  // turnaround spacing checks
  localparam logic [2:0] RUN_RESET             = 3'h0;
  localparam logic [2:0] RUN_MAX               = 3'h7;
  localparam logic [2:0] RUN_STEP              = 3'h1;
  localparam logic [2:0] MIN_IDLE_WR_BEFORE_WR = 3'h3;
  localparam logic [2:0] MIN_IDLE_RD_AFTER_RD  = 3'h2;

  // protocol error event positions
  localparam int ERR_RD_FOLLOW = 0;
  localparam int ERR_RD_GAP    = 1;
  localparam int ERR_WR_PRE    = 2;
  localparam int ERR_NUM       = 3;

  // error counter
  localparam int         ERR_CNT_WIDTH = 8;
  localparam logic [7:0] ERR_CNT_RESET = 8'h00;
  localparam logic [7:0] ERR_CNT_MAX   = 8'hff;

endpackage

// ==== verilog/level_sync2.sv ====
// two flip-flop synchroniser for levels
`timescale 1ns/1ps
`default_nettype none
module level_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic [WIDTH-1:0] i_d,
  output logic      [WIDTH-1:0] o_q
);

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] hold_reg;
  logic [WIDTH-1:0] hold_next;

  // first stage feeds only the second stage
  always_comb begin
    meta_next = i_d;
    hold_next = meta_reg;
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta_reg <= '0;
      hold_reg <= '0;
    end else begin
      meta_reg <= meta_next;
      hold_reg <= hold_next;
    end
  end

  assign o_q = hold_reg;

endmodule
`default_nettype wire

// ==== verilog/event_xing.sv ====
// toggle crossing that carries one-cycle events between clock domains
`timescale 1ns/1ps
`default_nettype none
module event_xing (
  input  wire logic i_src_clk,
  input  wire logic i_src_rstn,
  input  wire logic i_src_pulse,
  input  wire logic i_dst_clk,
  input  wire logic i_dst_rstn,
  output logic      o_dst_pulse
);

  logic toggle_reg;
  logic toggle_next;
  logic seen_reg;
  logic seen_next;
  logic pulse_reg;
  logic pulse_next;
  logic toggle_sync;

  // source side: each event flips the toggle
  always_comb begin
    toggle_next = toggle_reg ^ i_src_pulse;
  end

  always_ff @(posedge i_src_clk or negedge i_src_rstn) begin
    if (!i_src_rstn) begin
      toggle_reg <= 1'b0;
    end else begin
      toggle_reg <= toggle_next;
    end
  end

  level_sync2 #(
    .WIDTH (1)
  ) u_sync (
    .i_clk  (i_dst_clk),
    .i_rstn (i_dst_rstn),
    .i_d    (toggle_reg),
    .o_q    (toggle_sync)
  );

  // destination side: a change of the synced toggle is one event
  always_comb begin
    seen_next  = toggle_sync;
    pulse_next = toggle_sync ^ seen_reg;
  end

  always_ff @(posedge i_dst_clk or negedge i_dst_rstn) begin
    if (!i_dst_rstn) begin
      seen_reg  <= 1'b0;
      pulse_reg <= 1'b0;
    end else begin
      seen_reg  <= seen_next;
      pulse_reg <= pulse_next;
    end
  end

  assign o_dst_pulse = pulse_reg;

endmodule
`default_nettype wire

// ==== verilog/ddr_dq_turnaround_control.sv ====
// dq bus drive, low and termination control of a common-i/o ddr sram
`timescale 1ns/1ps
`default_nettype none
module ddr_dq_turnaround_control
  import ddr_dq_turn_pkg::*;
#(
  parameter int BEAT_W = BEAT_WIDTH,
  parameter int NBEATS = BEATS
) (
  // core domain
  input  wire logic                       I_CORE_CLK,
  input  wire logic                       I_RSTN,
  output logic [ERR_NUM-1:0]              O_SEQ_ERR,
  output logic [ERR_CNT_WIDTH-1:0]        O_SEQ_ERR_COUNT,
  output logic                            O_ODT_ACTIVE,
  // link domain, clocked by the master command clock
  input  wire logic                       I_MASTER_CMD_CLOCK,
  input  wire logic                       I_LOAD_STROBE_N,
  input  wire logic                       I_DIR_READ,
  input  wire logic [NBEATS*BEAT_W-1:0]   I_DQ_IN,
  output logic [NBEATS*BEAT_W-1:0]        O_DQ_OUT,
  output logic                            O_DQ_OE,
  output logic                            O_DQ_ODT_EN,
  output logic [1:0]                      O_BUS_STATE,
  output logic                            O_LINK_RD_REQ,
  input  wire logic [NBEATS*BEAT_W-1:0]   I_LINK_RD_DATA,
  output logic                            O_LINK_WR_VALID,
  output logic [NBEATS*BEAT_W-1:0]        O_LINK_WR_DATA
);

  localparam int DW = NBEATS * BEAT_W;

  //--------------------------------------------------------------------
  // link reset: asynchronous assert, release synchronised to link clock
  //--------------------------------------------------------------------
  logic [1:0] rsync_reg;
  logic [1:0] rsync_next;
  logic       link_rstn;

  // shift ones in after release; stage 0 feeds only stage 1
  always_comb begin
    rsync_next = {rsync_reg[0], 1'b1};
  end

  always_ff @(posedge I_MASTER_CMD_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rsync_reg <= 2'b00;
    end else begin
      rsync_reg <= rsync_next;
    end
  end

  assign link_rstn = rsync_reg[1];

  //--------------------------------------------------------------------
  // command sampling and history
  //--------------------------------------------------------------------
  // hist_reg[0] is the command of the last edge, hist_reg[k] is k edges older
  cmd_t hist_reg  [HIST_DEPTH];
  cmd_t hist_next [HIST_DEPTH];
  cmd_t cmd_now;

  // decode of the pins at this edge
  always_comb begin
    cmd_now = cmd_t'({I_LOAD_STROBE_N, I_DIR_READ});
  end

  // shift the command history by one each edge
  always_comb begin
    hist_next[0] = cmd_now;
    for (int k = 1; k < HIST_DEPTH; k++) begin
      hist_next[k] = hist_reg[k-1];
    end
  end

  always_ff @(posedge I_MASTER_CMD_CLOCK or negedge link_rstn) begin
    if (!link_rstn) begin
      for (int k = 0; k < HIST_DEPTH; k++) begin
        hist_reg[k] <= CMD_RESET;
      end
    end else begin
      for (int k = 0; k < HIST_DEPTH; k++) begin
        hist_reg[k] <= hist_next[k];
      end
    end
  end

  //--------------------------------------------------------------------
  // bus state for the coming cycle
  //--------------------------------------------------------------------
  // the cycle after this edge is two cycles after hist_reg[1] and three
  // after hist_reg[2]; both views agree, so one decode suffices
  bus_state_t state_next;
  logic       older_is_read;
  logic       newer_read_side;

  always_comb begin
    older_is_read   = (hist_reg[2] == CMD_READ);
    newer_read_side = hist_reg[1][DIR_BIT];
    if (newer_read_side) begin
      // read-side command: data after a read, else driven low
      state_next = older_is_read ? BUS_RDATA : BUS_LOW;
    end else begin
      // write-side command: terminate, unless a read was cut short
      state_next = older_is_read ? BUS_UNDEF : BUS_TERM;
    end
  end

  //--------------------------------------------------------------------
  // pin drive
  //--------------------------------------------------------------------
  bus_state_t  state_reg;
  logic [DW-1:0] dq_reg;
  logic [DW-1:0] dq_next;
  logic        oe_reg;
  logic        oe_next;
  logic        odt_reg;
  logic        odt_next;

  // drivers and termination are never on together
  always_comb begin
    dq_next  = '0;
    oe_next  = 1'b0;
    odt_next = 1'b0;
    case (state_next)
      BUS_RDATA: begin
        dq_next = I_LINK_RD_DATA;
        oe_next = 1'b1;
      end
      BUS_LOW: begin
        oe_next = 1'b1;
      end
      BUS_TERM: begin
        odt_next = 1'b1;
      end
      default: begin
        // undefined slot: stay off the bus and terminate
        odt_next = 1'b1;
      end
    endcase
  end

  always_ff @(posedge I_MASTER_CMD_CLOCK or negedge link_rstn) begin
    if (!link_rstn) begin
      state_reg <= BUS_LOW;
      dq_reg    <= '0;
      oe_reg    <= 1'b1;
      odt_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      dq_reg    <= dq_next;
      oe_reg    <= oe_next;
      odt_reg   <= odt_next;
    end
  end

  assign O_DQ_OUT    = dq_reg;
  assign O_DQ_OE     = oe_reg;
  assign O_DQ_ODT_EN = odt_reg;
  assign O_BUS_STATE = state_reg;

  //--------------------------------------------------------------------
  // user side: read request and write capture
  //--------------------------------------------------------------------
  logic          rd_req_reg;
  logic          rd_req_next;
  logic          wr_valid_reg;
  logic          wr_valid_next;
  logic [DW-1:0] wr_data_reg;
  logic [DW-1:0] wr_data_next;

  // read data is asked for one cycle after the read is sampled and
  // taken two edges later; write data is on the pins in the cycle of
  // the write and is caught at the end of that cycle, under termination
  always_comb begin
    rd_req_next   = (hist_reg[0] == CMD_READ);
    wr_valid_next = (hist_reg[0] == CMD_WRITE);
    wr_data_next  = wr_valid_next ? I_DQ_IN : wr_data_reg;
  end

  always_ff @(posedge I_MASTER_CMD_CLOCK or negedge link_rstn) begin
    if (!link_rstn) begin
      rd_req_reg   <= 1'b0;
      wr_valid_reg <= 1'b0;
      wr_data_reg  <= '0;
    end else begin
      rd_req_reg   <= rd_req_next;
      wr_valid_reg <= wr_valid_next;
      wr_data_reg  <= wr_data_next;
    end
  end

  assign O_LINK_RD_REQ   = rd_req_reg;
  assign O_LINK_WR_VALID = wr_valid_reg;
  assign O_LINK_WR_DATA  = wr_data_reg;

  //--------------------------------------------------------------------
  // sequence checks on the controller's commands
  //--------------------------------------------------------------------
  logic [2:0]         wr_run_reg;
  logic [2:0]         wr_run_next;
  logic [2:0]         rd_gap_reg;
  logic [2:0]         rd_gap_next;
  logic               after_rd_reg;
  logic               after_rd_next;
  logic [ERR_NUM-1:0] err_link;
  logic               prev_is_read;

  always_comb begin
    prev_is_read = (hist_reg[0] == CMD_READ);
    err_link     = '0;
    // a read must be followed by a read-side command
    err_link[ERR_RD_FOLLOW] = prev_is_read && !cmd_now[DIR_BIT];
    // at least two idle-reads between a read and the next write-side
    err_link[ERR_RD_GAP] = after_rd_reg && !cmd_now[DIR_BIT]
                           && (rd_gap_reg < MIN_IDLE_RD_AFTER_RD);
    // at least three write-side commands ahead of a write
    err_link[ERR_WR_PRE] = (cmd_now == CMD_WRITE)
                           && (wr_run_reg < MIN_IDLE_WR_BEFORE_WR);
  end

  // run counters saturate; a read restarts the idle-read gap
  always_comb begin
    wr_run_next   = wr_run_reg;
    rd_gap_next   = rd_gap_reg;
    after_rd_next = after_rd_reg;
    if (cmd_now[DIR_BIT]) begin
      wr_run_next = RUN_RESET;
      if (cmd_now == CMD_READ) begin
        rd_gap_next   = RUN_RESET;
        after_rd_next = 1'b1;
      end else if (rd_gap_reg != RUN_MAX) begin
        rd_gap_next = rd_gap_reg + RUN_STEP;
      end
    end else begin
      after_rd_next = 1'b0;
      if (wr_run_reg != RUN_MAX) begin
        wr_run_next = wr_run_reg + RUN_STEP;
      end
    end
  end

  always_ff @(posedge I_MASTER_CMD_CLOCK or negedge link_rstn) begin
    if (!link_rstn) begin
      wr_run_reg   <= RUN_RESET;
      rd_gap_reg   <= RUN_MAX;
      after_rd_reg <= 1'b0;
    end else begin
      wr_run_reg   <= wr_run_next;
      rd_gap_reg   <= rd_gap_next;
      after_rd_reg <= after_rd_next;
    end
  end

  //--------------------------------------------------------------------
  // crossings to the core domain
  //--------------------------------------------------------------------
  logic [ERR_NUM-1:0] err_core;

  for (genvar e = 0; e < ERR_NUM; e++) begin : g_err_xing
    event_xing u_err (
      .i_src_clk   (I_MASTER_CMD_CLOCK),
      .i_src_rstn  (link_rstn),
      .i_src_pulse (err_link[e]),
      .i_dst_clk   (I_CORE_CLK),
      .i_dst_rstn  (I_RSTN),
      .o_dst_pulse (err_core[e])
    );
  end

  level_sync2 #(
    .WIDTH (1)
  ) u_odt_sync (
    .i_clk  (I_CORE_CLK),
    .i_rstn (I_RSTN),
    .i_d    (odt_reg),
    .o_q    (O_ODT_ACTIVE)
  );

  //--------------------------------------------------------------------
  // core side error reporting
  //--------------------------------------------------------------------
  logic [ERR_NUM-1:0]       err_out_reg;
  logic [ERR_NUM-1:0]       err_out_next;
  logic [ERR_CNT_WIDTH-1:0] err_cnt_reg;
  logic [ERR_CNT_WIDTH-1:0] err_cnt_next;
  logic [ERR_CNT_WIDTH:0]   err_sum;

  // count every error event, saturating at the top
  always_comb begin
    err_out_next = err_core;
    err_sum      = {1'b0, err_cnt_reg};
    for (int e = 0; e < ERR_NUM; e++) begin
      err_sum = err_sum + {{ERR_CNT_WIDTH{1'b0}}, err_core[e]};
    end
    if (err_sum[ERR_CNT_WIDTH] || (err_sum[ERR_CNT_WIDTH-1:0] == ERR_CNT_MAX)) begin
      err_cnt_next = ERR_CNT_MAX;
    end else begin
      err_cnt_next = err_sum[ERR_CNT_WIDTH-1:0];
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      err_out_reg <= '0;
      err_cnt_reg <= ERR_CNT_RESET;
    end else begin
      err_out_reg <= err_out_next;
      err_cnt_reg <= err_cnt_next;
    end
  end

  assign O_SEQ_ERR       = err_out_reg;
  assign O_SEQ_ERR_COUNT = err_cnt_reg;

endmodule
`default_nettype wire

// ==== verif/ddr_dq_turn_checker_assertions.sv ====
// concurrent checks on the ports of the dq turnaround controller
`timescale 1ns/1ps
`default_nettype none
module ddr_dq_turn_checker
  import ddr_dq_turn_pkg::*;
#(
  parameter int BEAT_W = BEAT_WIDTH,
  parameter int NBEATS = BEATS
) (
  input wire logic                     I_CORE_CLK,
  input wire logic                     I_RSTN,
  input wire logic [ERR_NUM-1:0]       O_SEQ_ERR,
  input wire logic [ERR_CNT_WIDTH-1:0] O_SEQ_ERR_COUNT,
  input wire logic                     I_MASTER_CMD_CLOCK,
  input wire logic                     I_LOAD_STROBE_N,
  input wire logic                     I_DIR_READ,
  input wire logic [NBEATS*BEAT_W-1:0] I_DQ_IN,
  input wire logic [NBEATS*BEAT_W-1:0] O_DQ_OUT,
  input wire logic                     O_DQ_OE,
  input wire logic                     O_DQ_ODT_EN,
  input wire logic [1:0]               O_BUS_STATE,
  input wire logic                     O_LINK_RD_REQ,
  input wire logic [NBEATS*BEAT_W-1:0] I_LINK_RD_DATA,
  input wire logic                     O_LINK_WR_VALID,
  input wire logic [NBEATS*BEAT_W-1:0] O_LINK_WR_DATA
);
  // read and write decode of the sampled pins
  wire logic rd = ({I_LOAD_STROBE_N, I_DIR_READ} == CMD_READ);
  wire logic wr = ({I_LOAD_STROBE_N, I_DIR_READ} == CMD_WRITE);

  // link edges since reset release; history checks wait until it is real
  logic [2:0] warm_reg;
  always_ff @(posedge I_MASTER_CMD_CLOCK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      warm_reg <= 3'h0;
    end else if (warm_reg != 3'h7) begin
      warm_reg <= warm_reg + 3'h1;
    end
  end
  wire logic warm = (warm_reg == 3'h7);

  // bus state from the prior command and the direction of the one after it
  state_map_a: assert property (@(posedge I_MASTER_CMD_CLOCK) disable iff (!I_RSTN || !warm)
    O_BUS_STATE == ($past(I_DIR_READ, 3) ? ($past(rd, 4) ? BUS_RDATA : BUS_LOW)
                                         : ($past(rd, 4) ? BUS_UNDEF : BUS_TERM)))
    else $error("bus state wrong for command history");
  drive_map_a: assert property (@(posedge I_MASTER_CMD_CLOCK) disable iff (!I_RSTN || !warm)
    O_DQ_OE == $past(I_DIR_READ, 3) && O_DQ_ODT_EN == !$past(I_DIR_READ, 3))
    else $error("drive or termination does not follow direction");
  drive_excl_a: assert property (@(posedge I_MASTER_CMD_CLOCK) disable iff (!I_RSTN || !warm)
    !(O_DQ_OE && O_DQ_ODT_EN)) else $error("drive and termination both on");
  rd_out_a: assert property (@(posedge I_MASTER_CMD_CLOCK) disable iff (!I_RSTN || !warm)
    O_DQ_OUT == ((O_BUS_STATE == BUS_RDATA) ? $past(I_LINK_RD_DATA) : '0))
    else $error("drive data wrong");
  rd_req_a: assert property (@(posedge I_MASTER_CMD_CLOCK) disable iff (!I_RSTN || !warm)
    O_LINK_RD_REQ == $past(rd, 2)) else $error("read request misplaced");
  wr_cap_a: assert property (@(posedge I_MASTER_CMD_CLOCK) disable iff (!I_RSTN || !warm)
    O_LINK_WR_VALID == $past(wr, 2) && (!O_LINK_WR_VALID || O_LINK_WR_DATA == $past(I_DQ_IN)))
    else $error("write capture misplaced");
  low_lead_a: assert property (@(posedge I_MASTER_CMD_CLOCK) disable iff (!I_RSTN || !warm)
    $past(rd, 3) && !$past(rd, 4) |-> O_BUS_STATE == BUS_LOW && O_DQ_OE
    ##1 (O_BUS_STATE == BUS_RDATA || !$past(I_DIR_READ, 3)))
    else $error("no low cycle ahead of read data");
  odt_drop_a: assert property (@(posedge I_MASTER_CMD_CLOCK) disable iff (!I_RSTN || !warm)
    $past(wr, 4) && $past(I_DIR_READ, 3) |-> !O_DQ_ODT_EN && $past(O_DQ_ODT_EN))
    else $error("termination not dropped after write");
  cnt_step_a: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
    O_SEQ_ERR_COUNT != $past(O_SEQ_ERR_COUNT) |->
    (O_SEQ_ERR != 0 || $past(O_SEQ_ERR) != 0) && O_SEQ_ERR_COUNT > $past(O_SEQ_ERR_COUNT))
    else $error("error count moved without an event");

  // main scenarios reached
  cov_rdata: cover property (@(posedge I_MASTER_CMD_CLOCK) O_BUS_STATE == BUS_RDATA);
  cov_undef: cover property (@(posedge I_MASTER_CMD_CLOCK) O_BUS_STATE == BUS_UNDEF);
  cov_err: cover property (@(posedge I_CORE_CLK) O_SEQ_ERR != 0);
endmodule

bind ddr_dq_turnaround_control ddr_dq_turn_checker #(.BEAT_W(BEAT_W), .NBEATS(NBEATS)) i_chk (
  .I_CORE_CLK(I_CORE_CLK), .I_RSTN(I_RSTN), .O_SEQ_ERR(O_SEQ_ERR),
  .O_SEQ_ERR_COUNT(O_SEQ_ERR_COUNT), .I_MASTER_CMD_CLOCK(I_MASTER_CMD_CLOCK),
  .I_LOAD_STROBE_N(I_LOAD_STROBE_N), .I_DIR_READ(I_DIR_READ), .I_DQ_IN(I_DQ_IN),
  .O_DQ_OUT(O_DQ_OUT), .O_DQ_OE(O_DQ_OE), .O_DQ_ODT_EN(O_DQ_ODT_EN),
  .O_BUS_STATE(O_BUS_STATE), .O_LINK_RD_REQ(O_LINK_RD_REQ), .I_LINK_RD_DATA(I_LINK_RD_DATA),
  .O_LINK_WR_VALID(O_LINK_WR_VALID), .O_LINK_WR_DATA(O_LINK_WR_DATA));
`default_nettype wire

// ==== verif/ddr_ctrl_model.sv ====
// memory-controller model: commands, write words and read words
`timescale 1ns/1ps
`default_nettype none
module ddr_ctrl_model
  import ddr_dq_turn_pkg::*;
(
  input  wire logic                    i_clk,
  input  wire logic                    i_rd_req,
  output logic                         o_load_strobe_n,
  output logic                         o_dir_read,
  output logic [BEATS*BEAT_WIDTH-1:0]  o_dq,
  output logic [BEATS*BEAT_WIDTH-1:0]  o_rd_data
);
  cmd_t                        hist [1:4] = '{default: CMD_IDLE_RD};
  logic [BEATS*BEAT_WIDTH-1:0] wq [$];
  logic [BEATS*BEAT_WIDTH-1:0] rd_word = 36'h0_1234_5678;
  logic                        req;

  // idle-read at start keeps the bus driven low
  initial begin
    {o_load_strobe_n, o_dir_read} = CMD_IDLE_RD;
    o_dq = '0;
    o_rd_data = '0;
  end

  // one command on the pins just after the edge; spacing comes from the caller
  task automatic issue(input cmd_t c, input logic [BEATS*BEAT_WIDTH-1:0] wd);
    @(posedge i_clk);
    #1;
    {o_load_strobe_n, o_dir_read} = c;
    if (c == CMD_WRITE) wq.push_back(wd);
  endtask

  // history of sampled commands, write word for the capture edge, read word on request
  always @(posedge i_clk) begin
    req = i_rd_req;
    for (int k = 4; k > 1; k--) hist[k] = hist[k-1];
    hist[1] = cmd_t'({o_load_strobe_n, o_dir_read});
    #1;
    if (hist[1] == CMD_WRITE && wq.size() > 0) o_dq = wq.pop_front();
    else o_dq = ~o_dq;
    rd_word = req ? rd_word + 36'h0_0001_0001 : rd_word;
    o_rd_data = req ? rd_word : ~o_rd_data;
  end
endmodule
`default_nettype wire

// ==== verif/ddr_dq_turnaround_control_tb.sv ====
// self-checking bench for the dq turnaround controller
`timescale 1ns/1ps
`default_nettype none
module ddr_dq_turnaround_control_tb
  import ddr_dq_turn_pkg::*;
;
  localparam int W = BEATS * BEAT_WIDTH;
  localparam logic [W-1:0] RD_BASE = 36'h0_1234_5678;
  localparam logic [W-1:0] RD_STEP = 36'h0_0001_0001;
  logic [W-1:0]             rd_n = '0;
  logic [W-1:0]             rd_exp;
  logic                     core_clk, link_clk, rstn, lsn, dir, oe, odt, odt_act, rd_req, wr_vld;
  logic [W-1:0]             dq_in, dq_out, rd_data, wr_data;
  logic [1:0]               bus_state;
  logic [ERR_NUM-1:0]       seq_err;
  logic [ERR_NUM-1:0]       err_seen = '0;
  logic [ERR_CNT_WIDTH-1:0] err_cnt;
  int                       fail_count, num_checks, cycles;
  cmd_t                     h [1:4] = '{default: CMD_IDLE_RD};
  logic [W-1:0]             wexp [$];

  ddr_dq_turnaround_control i_dut (
    .I_CORE_CLK(core_clk), .I_RSTN(rstn), .O_SEQ_ERR(seq_err), .O_SEQ_ERR_COUNT(err_cnt),
    .O_ODT_ACTIVE(odt_act), .I_MASTER_CMD_CLOCK(link_clk), .I_LOAD_STROBE_N(lsn),
    .I_DIR_READ(dir), .I_DQ_IN(dq_in), .O_DQ_OUT(dq_out), .O_DQ_OE(oe), .O_DQ_ODT_EN(odt),
    .O_BUS_STATE(bus_state), .O_LINK_RD_REQ(rd_req), .I_LINK_RD_DATA(rd_data),
    .O_LINK_WR_VALID(wr_vld), .O_LINK_WR_DATA(wr_data));
  ddr_ctrl_model i_ctrl (.i_clk(link_clk), .i_rd_req(rd_req), .o_load_strobe_n(lsn),
    .o_dir_read(dir), .o_dq(dq_in), .o_rd_data(rd_data));

  // clocks of unrelated phase
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #3;
    forever #6 link_clk = ~link_clk;
  end

  task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  function automatic logic [1:0] exp_state(input cmd_t prev, input cmd_t nxt);
    if (nxt[DIR_BIT]) return (prev == CMD_READ) ? BUS_RDATA : BUS_LOW;
    return (prev == CMD_READ) ? BUS_UNDEF : BUS_TERM;
  endfunction

  // reference bus state from the sampled command history, write capture from the queued write words
  always @(posedge link_clk) begin
    if (rstn === 1'b1) begin
      check(bus_state, exp_state(h[4], h[3]));
      if (h[4] == CMD_READ) rd_n++;
      rd_exp = (exp_state(h[4], h[3]) == BUS_RDATA) ? RD_BASE + rd_n * RD_STEP : '0;
      check(dq_out, rd_exp);
      if (wr_vld === 1'b1) check(wr_data, wexp.pop_front());
    end
    for (int k = 4; k > 1; k--) h[k] = h[k-1];
    h[1] = cmd_t'({lsn, dir});
  end

  // sticky error flags and a hang limit
  always @(posedge core_clk) begin
    err_seen <= err_seen | seq_err;
    cycles++;
    if (cycles == 6000) begin
      fail_count++;
      conclude();
    end
  end

  // sequence: R read, r idle-read, W write, w idle-write; then drain and judge flags
  task automatic run(input string s, input logic [ERR_NUM-1:0] eb, input int ne);
    logic [ERR_CNT_WIDTH-1:0] c0;
    logic [W-1:0]             wd;
    cmd_t                     c;
    c0 = err_cnt;
    err_seen = '0;
    for (int i = 0; i < s.len(); i++) begin
      c = (s[i] == "R") ? CMD_READ : (s[i] == "W") ? CMD_WRITE :
          (s[i] == "w") ? CMD_IDLE_WR : CMD_IDLE_RD;
      wd = {4'h0, 32'hC0DE_0000 + 32'(i)};
      if (c == CMD_WRITE) wexp.push_back(wd);
      i_ctrl.issue(c, wd);
    end
    repeat (8) i_ctrl.issue(CMD_IDLE_RD, '0);
    repeat (4) @(posedge core_clk);
    check(err_seen, eb);
    check(err_cnt - c0, ne);
    $display("run %s done", s);
  endtask

  // every truth-table case but the undefined bus on a legal stream, exact minimum spacings included
  task automatic t_table;
    run("rRRrrwwwWWRrrrwwwwWwrRr", 3'b000, 0);
  endtask

  // illegal turnarounds: undefined bus and flagged spacing
  task automatic t_invalid;
    run("Rw", 3'b011, 2);
    run("Rrw", 3'b010, 1);
    run("wwW", 3'b100, 1);
    run("RW", 3'b111, 3);
  endtask

  // termination level seen from the core domain
  task automatic t_odt_level;
    repeat (8) i_ctrl.issue(CMD_IDLE_WR, '0);
    repeat (4) @(posedge core_clk);
    check(odt_act, 1'b1);
    repeat (8) i_ctrl.issue(CMD_IDLE_RD, '0);
    repeat (4) @(posedge core_clk);
    check(odt_act, 1'b0);
    $display("odt level done");
  endtask

  // reset in mid-run: bus back to low drive, error count cleared
  task automatic t_reset;
    @(posedge core_clk);
    #1;
    rstn = 1'b0;
    repeat (2) @(posedge link_clk);
    #1;
    check(bus_state, BUS_LOW);
    check({oe, odt, wr_vld, rd_req}, 4'h8);
    check(err_cnt, 8'h00);
    @(posedge core_clk);
    #1;
    rstn = 1'b1;
    repeat (4) i_ctrl.issue(CMD_IDLE_RD, '0);
    run("rrwwwWr", 3'b000, 0);
    $display("reset done");
  endtask

  initial begin
    rstn = 1'b0;
    repeat (2) @(posedge link_clk);
    @(posedge core_clk);
    #1;
    rstn = 1'b1;
    repeat (4) i_ctrl.issue(CMD_IDLE_RD, '0);
    t_table();
    t_invalid();
    t_odt_level();
    t_reset();
    conclude();
  end
endmodule
`default_nettype wire
